// ### logic/shutdown_deghost_ctrl.sv
// shutdown gating and de-ghost resistor control for the matrix outputs
// assumes register file lives elsewhere and presents held values as levels
`timescale 1ns/1ps
`default_nettype none
module shutdown_deghost_ctrl
  import deghost_pkg::*;
#(
  parameter int N_ROWS = deghost_pkg::ROWS,
  parameter int N_COLS = deghost_pkg::COLS
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic shutdown_pin_n_in,
  input wire logic soft_shutdown_n_bit_in,
  input wire logic [deghost_pkg::RES_SEL_W-1:0] res_sel_in,
  input wire logic [N_ROWS-1:0] row_source_switch_on_in,
  input wire logic [N_COLS-1:0] column_current_sink_on_in,
  output logic [N_ROWS-1:0] row_source_switch_out,
  output logic [N_COLS-1:0] column_current_sink_out,
  output logic [N_ROWS-1:0] row_pulldown_en_out,
  output logic [N_COLS-1:0] column_pullup_en_out,
  output logic [deghost_pkg::SEL_W-1:0] row_pulldown_sel_out,
  output logic [deghost_pkg::SEL_W-1:0] column_pullup_sel_out,
  output logic active_out,
  output logic if_reset_out
);
  import deghost_pkg::*;

  // width of the interface reset stretch counter
  localparam int IF_CNT_W = 8;

  // all state of the block except the pin edge detector lives in this one record
  typedef struct packed {
    logic [N_ROWS-1:0] row;
    logic [N_COLS-1:0] col;
    logic [N_ROWS-1:0] row_pd;
    logic [N_COLS-1:0] col_pu;
    logic [SEL_W-1:0] row_sel;
    logic [SEL_W-1:0] col_sel;
    logic active;
    logic if_rst;
    logic [IF_CNT_W-1:0] if_cnt;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  // rising edge of the shutdown pin, one cycle wide
  logic pin_rise;

  // combined run level of pin and soft bit
  logic run_lvl;

  // selection fields cut out of the held resistor value
  logic [SEL_W-1:0] row_sel_field;
  logic [SEL_W-1:0] col_sel_field;

  // nonzero selection means the resistor bank is in use
  logic sel_row_on;
  logic sel_col_on;

  // per-output wanted drive after shutdown gating
  logic [N_ROWS-1:0] row_want;
  logic [N_COLS-1:0] col_want;

  // per-output resistor enables derived from the gated drive
  logic [N_ROWS-1:0] row_pd_want;
  logic [N_COLS-1:0] col_pu_want;

  edge_rise u_pin_edge (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .level_in(shutdown_pin_n_in),
    .rise_out(pin_rise)
  );

  // a zero selection field means that resistor is disconnected entirely
  function automatic logic sel_enabled(input logic [SEL_W-1:0] sel);
    sel_enabled = (sel != '0);
  endfunction

  // either shutdown source alone is enough to blank the matrix
  function automatic logic run_allowed(input logic pin_n, input logic soft_n);
    run_allowed = pin_n & soft_n;
  endfunction

  // a resistor never sits on a conducting output, so it burns no power
  function automatic logic resistor_on(input logic enabled, input logic conducting);
    resistor_on = enabled & ~conducting;
  endfunction

  assign run_lvl = run_allowed(shutdown_pin_n_in, soft_shutdown_n_bit_in);

  // shutdown only gates outputs; the held settings are never touched here
  assign row_sel_field = res_sel_in[ROW_SEL_LSB +: SEL_W];
  assign col_sel_field = res_sel_in[COL_SEL_LSB +: SEL_W];

  assign sel_row_on = sel_enabled(row_sel_field);
  assign sel_col_on = sel_enabled(col_sel_field);

  genvar gi;
  generate
    // one row switch and its pull-down per slice
    for (gi = 0; gi < N_ROWS; gi++)
    begin : g_row
      assign row_want[gi] = run_lvl & row_source_switch_on_in[gi];
      assign row_pd_want[gi] = resistor_on(sel_row_on, row_want[gi]);
    end
    // one column sink and its pull-up per slice
    for (gi = 0; gi < N_COLS; gi++)
    begin : g_col
      assign col_want[gi] = run_lvl & column_current_sink_on_in[gi];
      assign col_pu_want[gi] = resistor_on(sel_col_on, col_want[gi]);
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.active = run_lvl;
    st_nxt.row_sel = row_sel_field;
    st_nxt.col_sel = col_sel_field;
    st_nxt.row = row_want;
    st_nxt.col = col_want;
    st_nxt.row_pd = row_pd_want;
    st_nxt.col_pu = col_pu_want;
    // the interface reset is stretched to a fixed count of cycles;
    // a new pin edge during the stretch restarts it
    if (pin_rise)
    begin
      st_nxt.if_rst = 1'b1;
      st_nxt.if_cnt = IF_CNT_W'(IF_RST_CYC - 1);
    end
    else if (st_r.if_cnt != '0)
    begin
      st_nxt.if_rst = 1'b1;
      st_nxt.if_cnt = st_r.if_cnt - IF_CNT_W'(1);
    end
    else
    begin
      st_nxt.if_rst = 1'b0;
      st_nxt.if_cnt = '0;
    end
  end

  // reset clears every output, so the matrix stays dark until the
  // first edge after release has sampled pin and soft bit
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // every output is a plain copy of a state flip-flop, so the pad
  // drivers see no glitches from the gating logic above

  assign row_source_switch_out = st_r.row;
  assign column_current_sink_out = st_r.col;
  assign row_pulldown_en_out = st_r.row_pd;
  assign column_pullup_en_out = st_r.col_pu;
  assign row_pulldown_sel_out = st_r.row_sel;
  assign column_pullup_sel_out = st_r.col_sel;
  assign active_out = st_r.active;
  assign if_reset_out = st_r.if_rst;
endmodule
`default_nettype wire

// ### logic/deghost_pkg.sv
// constants shared by the shutdown and de-ghost control block
// assumes a single 100 MHz core clock and no software-visible registers
package deghost_pkg;
  localparam int ROWS = 9;
  localparam int COLS = 16;
  localparam int RES_SEL_W = 8;
  localparam logic [7:0] RES_SEL_RST = 8'h00;
  localparam int ROW_SEL_LSB = 4;
  localparam int COL_SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int QUIET_NS = 10000;
  localparam int CLK_NS = 10;
  localparam int QUIET_CYC = QUIET_NS / CLK_NS;
  localparam int IF_RST_CYC = 1;
endpackage

// ### logic/edge_rise.sv
// rising edge detector on a synchronous level
// assumes input already synchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
module edge_rise (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  output logic rise_out
);
  typedef struct packed {
    logic prev;
    logic rise;
  } edge_state_t;
  edge_state_t st_r;
  edge_state_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = level_in;
    st_nxt.rise = level_in & ~st_r.prev;
  end
  // prev resets high so a pin held high at reset gives no false edge
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_r <= '{prev: 1'b1, rise: 1'b0};
    else
      st_r <= st_nxt;
  end
  assign rise_out = st_r.rise;
endmodule
`default_nettype wire

// ### testbench/deghost_chk.sv
// port checker for the shutdown and de-ghost control block
// assumes binding onto shutdown_deghost_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module deghost_chk #(parameter int N_ROWS = 9, parameter int N_COLS = 16) (
  input wire logic core_clk_in, rst_n_in, shutdown_pin_n_in, soft_shutdown_n_bit_in, active_out, if_reset_out,
  input wire logic [7:0] res_sel_in,
  input wire logic [2:0] row_pulldown_sel_out, column_pullup_sel_out,
  input wire logic [N_ROWS-1:0] row_source_switch_on_in, row_source_switch_out, row_pulldown_en_out,
  input wire logic [N_COLS-1:0] column_current_sink_on_in, column_current_sink_out, column_pullup_en_out);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_soft_blank: assert property (!$past(soft_shutdown_n_bit_in) |-> column_current_sink_out == 0)
    else $error("sinks on in soft shutdown");
  chk_pin_blank: assert property (!$past(shutdown_pin_n_in) |-> !active_out && row_source_switch_out == 0)
    else $error("switches on in pin shutdown");
  chk_pin_resume: assert property ($past(rst_n_in) && $past(shutdown_pin_n_in) && $past(soft_shutdown_n_bit_in) |-> active_out)
    else $error("no resume");
  chk_col_sel: assert property ($past(rst_n_in) |-> column_pullup_sel_out == $past(res_sel_in[2:0]))
    else $error("column select wrong");
  chk_normal_drive: assert property (active_out |-> row_source_switch_out == $past(row_source_switch_on_in))
    else $error("row drive wrong");
  chk_row_deghost: assert property (row_pulldown_en_out == (row_pulldown_sel_out != 0 ? ~row_source_switch_out : '0))
    else $error("pull-down wrong");
  chk_col_deghost: assert property (column_pullup_en_out == (column_pullup_sel_out != 0 ? ~column_current_sink_out : '0))
    else $error("pull-up wrong");
  chk_sel_apply: assert property ($past(rst_n_in) |-> row_pulldown_sel_out == $past(res_sel_in[6:4]))
    else $error("row select wrong");
  chk_if_pulse: assert property ($rose(shutdown_pin_n_in) && $past(rst_n_in) |-> ##2 if_reset_out ##1 !if_reset_out)
    else $error("interface reset pulse wrong");
endmodule
bind shutdown_deghost_ctrl deghost_chk #(.N_ROWS(N_ROWS), .N_COLS(N_COLS)) u_chk (.*);
`default_nettype wire

// ### testbench/scan_model.sv
// scan engine stand-in feeding wanted row and sink states
// assumes the bench clock; pattern moves every cycle so gating shows
`timescale 1ns/1ps
`default_nettype none
module scan_model (
  input wire logic core_clk_in,
  output logic [24:0] wanted_out
);
  initial wanted_out = 25'h00000a5;
  always @(posedge core_clk_in)
    wanted_out <= #1 ~{wanted_out[23:0], wanted_out[24]};
endmodule
`default_nettype wire

// ### testbench/matrix_shutdown_deghost_ctrl_tb.sv
// self-checking bench for the shutdown and de-ghost control block
// assumes scan_model as source of wanted states
`timescale 1ns/1ps
`default_nettype none
module matrix_shutdown_deghost_ctrl_tb;
  logic core_clk_in = 0, rst_n_in = 0, shutdown_pin_n_in = 1, soft_shutdown_n_bit_in = 1, active_out, if_reset_out;
  logic [7:0] res_sel_in = 8'h00;
  logic [2:0] row_pulldown_sel_out, column_pullup_sel_out;
  logic [8:0] row_source_switch_on_in, row_source_switch_out, row_pulldown_en_out;
  logic [15:0] column_current_sink_on_in, column_current_sink_out, column_pullup_en_out, c;
  logic [8:0] r;
  int error_cnt = 0, cmp_count = 0;
  initial forever #5 core_clk_in = ~core_clk_in;
  scan_model u_scan (.core_clk_in, .wanted_out({row_source_switch_on_in, column_current_sink_on_in}));
  shutdown_deghost_ctrl u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .shutdown_pin_n_in(shutdown_pin_n_in),
    .soft_shutdown_n_bit_in(soft_shutdown_n_bit_in), .res_sel_in(res_sel_in),
    .row_source_switch_on_in(row_source_switch_on_in), .column_current_sink_on_in(column_current_sink_on_in),
    .row_source_switch_out(row_source_switch_out), .column_current_sink_out(column_current_sink_out),
    .row_pulldown_en_out(row_pulldown_en_out), .column_pullup_en_out(column_pullup_en_out),
    .row_pulldown_sel_out(row_pulldown_sel_out), .column_pullup_sel_out(column_pullup_sel_out),
    .active_out(active_out), .if_reset_out(if_reset_out));
  task automatic cmp(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic look(input logic p, s, input logic [7:0] v);
    @(posedge core_clk_in) #1 {shutdown_pin_n_in, soft_shutdown_n_bit_in, res_sel_in} = {p, s, v};
    @(negedge core_clk_in) c = (p & s) ? column_current_sink_on_in : 16'h0000;
    r = (p & s) ? row_source_switch_on_in : 9'h000;
    @(posedge core_clk_in) #2 cmp("sink", c, column_current_sink_out);
    cmp("row", {7'h00, r}, {7'h00, row_source_switch_out});
    cmp("active", {15'h0000, p & s}, {15'h0000, active_out});
    cmp("pullup", |v[2:0] ? ~c : 16'h0000, column_pullup_en_out);
    cmp("pulldown", |v[6:4] ? {7'h00, ~r} : 16'h0000, {7'h00, row_pulldown_en_out});
    cmp("sel", {13'h0000, v[2:0]}, {13'h0000, column_pullup_sel_out});
    cmp("rowsel", {13'h0000, v[6:4]}, {13'h0000, row_pulldown_sel_out});
  endtask
  task automatic t_modes;
    for (int i = 0; i < 8; i++)
      look(i[0], i[1], i[2] ? 8'h35 : 8'h00);
  endtask
  task automatic t_wake;
    // selection rewritten while the pin is low, nothing else on the bus near the edge
    look(0, 1, 8'h21);
    @(posedge core_clk_in) #1 shutdown_pin_n_in = 1;
    repeat (2) @(posedge core_clk_in);
    #2 cmp("ifrst", 16'h0001, {15'h0000, if_reset_out});
    @(posedge core_clk_in) #2 cmp("ifrst", 16'h0000, {15'h0000, if_reset_out});
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    #1 rst_n_in = 1;
    t_modes;
    t_wake;
    test_done;
  end
endmodule
`default_nettype wire
